//--- hdl/rbs_block_sync_buffer.v
`timescale 1ns/10ps
`default_nettype none
`include "rbs_defines.vh"
module rbs_block_sync_buffer #(
	parameter NBLK_CYC = `RBS_NBLK_CYC
) (
	// clock and reset
	input  wire        pclk,
	input  wire        presetn,
	// apb slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// demodulated bit stream (pin side)
	input  wire        rds_bit,
	input  wire        rds_bit_clk,
	// outputs
	output wire        irq_out_n,
	output wire        new_block_pulse_n,
	output wire        locked
);
	// ==========================================================
	// state codes, one-hot
	localparam ST_SEARCH = 3'b001;
	localparam ST_ACQ    = 3'b010;
	localparam ST_LOCK   = 3'b100;
	// ==========================================================
	// next identity in cyclic order
	function [2:0] next_id;
		input [2:0] id;
		input       rbds_e;
		begin
			if (rbds_e) begin
				next_id = `RBS_ID_A;
			end else if (id == `RBS_ID_A) begin
				next_id = `RBS_ID_B;
			end else if (id == `RBS_ID_B) begin
				next_id = `RBS_ID_C;
			end else if (id == `RBS_ID_C || id == `RBS_ID_CP) begin
				next_id = `RBS_ID_D;
			end else begin
				next_id = `RBS_ID_A;
			end
		end
	endfunction
	// ==========================================================
	// pin synchronisers, three stages each
	reg [2:0] bit_sync;
	reg [2:0] clk_sync;
	reg       clk_state;
	reg       bit_state;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bit_sync  <= 3'h0;
			clk_sync  <= 3'h0;
			clk_state <= 1'b0;
			bit_state <= 1'b0;
		end else begin
			bit_sync <= {bit_sync[1:0], rds_bit};
			clk_sync <= {clk_sync[1:0], rds_bit_clk};
			if (clk_sync[1] == clk_sync[2]) begin
				clk_state <= clk_sync[2];
			end
			if (bit_sync[1] == bit_sync[2]) begin
				bit_state <= bit_sync[2];
			end
		end
	end
	// a rising edge of the filtered bit clock samples the data bit
	wire bit_strobe = clk_sync[1] && clk_sync[2] && !clk_state;
	// ==========================================================
	// registers written by software
	reg [1:0] mode;
	reg       rbds;
	reg       ready_irq_mask;
	reg [5:0] bad_limit_to_lose;
	reg [5:0] good_limit_reset;
	reg [5:0] bad_limit_to_acquire;
	// apb, always zero wait
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	wire   wr_en   = psel && penable && pwrite;
	wire   rd_en   = psel && penable && !pwrite;
	wire   restart_search = wr_en && paddr == `RBS_REG_CTRL && pwdata[`RBS_CTRL_RESTART];
	// host read byte strobe: write of a byte number emulates a read of that map byte
	wire       byte_rd = wr_en && paddr == `RBS_REG_RDBYTE;
	wire [4:0] byte_no = pwdata[4:0];
	// writes into configuration; acquire limit saturates at 32
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode                 <= `RBS_MODE_PER;
			rbds                 <= 1'b0;
			ready_irq_mask       <= 1'b0;
			bad_limit_to_lose    <= `RBS_BBL_RST;
			good_limit_reset     <= `RBS_GBL_RST;
			bad_limit_to_acquire <= {1'b0, `RBS_BBG_RST};
		end else if (wr_en && paddr == `RBS_REG_CTRL) begin
			mode           <= pwdata[1:0];
			rbds           <= pwdata[`RBS_CTRL_RBDS];
			ready_irq_mask <= pwdata[`RBS_CTRL_MASK];
		end else if (wr_en && paddr == `RBS_REG_LIMITS) begin
			bad_limit_to_lose    <= pwdata[5:0];
			good_limit_reset     <= pwdata[13:8];
			bad_limit_to_acquire <= (pwdata[21:16] > 6'h20) ? 6'h20 : pwdata[21:16];
		end
	end
	// ==========================================================
	// shift window and syndrome check
	reg  [25:0] window;
	reg  [4:0]  bit_cnt;
	wire [2:0]  ident;
	// judge the window as it stands once the strobed bit is in, so a block is
	// seen on its own last bit and not one bit late on the next block's first
	wire [25:0] next_window = {window[24:0], bit_state};
	rbs_syndrome u_syn (
		.window (next_window),
		.rbds   (rbds),
		.ident  (ident)
	);
	// ==========================================================
	// synchroniser state machine
	reg [2:0] state;
	reg [2:0] expect_id;
	reg       first_e;
	reg [5:0] acq_bad;
	reg [5:0] good_run_count;
	reg [5:0] bad_run_count;
	reg       lock_lost_flag;
	reg       blk_done;
	reg       blk_good;
	reg [2:0] blk_id;
	reg       lock_gain;
	wire      win_full = bit_cnt == 5'h19;
	wire      id_ok    = ident == expect_id || (expect_id == `RBS_ID_C && ident == `RBS_ID_CP);
	// search slides a bit at a time, acquire and lock take whole blocks
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			window         <= 26'h0;
			bit_cnt        <= 5'h0;
			state          <= ST_SEARCH;
			expect_id      <= `RBS_ID_A;
			first_e        <= 1'b0;
			acq_bad        <= 6'h0;
			good_run_count <= 6'h0;
			bad_run_count  <= 6'h0;
			lock_lost_flag <= 1'b0;
			blk_done       <= 1'b0;
			blk_good       <= 1'b0;
			blk_id         <= `RBS_ID_NONE;
			lock_gain      <= 1'b0;
		end else begin
			blk_done  <= 1'b0;
			lock_gain <= 1'b0;
			// lock-lost clears on a flags byte read; loss in same cycle wins
			if (byte_rd && byte_no == `RBS_BYTE_FLAGS) begin
				lock_lost_flag <= 1'b0;
			end
			if (restart_search) begin
				state   <= ST_SEARCH;
				bit_cnt <= 5'h0;
			end else if (bit_strobe) begin
				window <= next_window;
				case (state)
					ST_SEARCH: begin
						if (ident != `RBS_ID_NONE) begin
							state     <= ST_ACQ;
							bit_cnt   <= 5'h0;
							acq_bad   <= 6'h0;
							first_e   <= ident == `RBS_ID_E;
							expect_id <= next_id(ident, ident == `RBS_ID_E);
							blk_done  <= 1'b1;
							blk_good  <= 1'b1;
							blk_id    <= ident;
						end
					end
					ST_ACQ: begin
						bit_cnt <= win_full ? 5'h0 : bit_cnt + 5'h1;
						if (win_full) begin
							blk_done <= 1'b1;
							blk_id   <= ident;
							blk_good <= id_ok;
							if (id_ok) begin
								state          <= ST_LOCK;
								lock_gain      <= 1'b1;
								expect_id      <= next_id(ident, 1'b0);
								good_run_count <= 6'h0;
								bad_run_count  <= 6'h0;
							end else if (acq_bad + 6'h1 >= bad_limit_to_acquire) begin
								state <= ST_SEARCH;
							end else begin
								acq_bad   <= acq_bad + 6'h1;
								expect_id <= next_id(expect_id, first_e);
							end
						end
					end
					ST_LOCK: begin
						bit_cnt <= win_full ? 5'h0 : bit_cnt + 5'h1;
						if (win_full) begin
							blk_done  <= 1'b1;
							blk_id    <= id_ok ? ident : expect_id;
							blk_good  <= id_ok;
							expect_id <= next_id(expect_id, 1'b0);
							if (id_ok && good_run_count + 6'h1 == good_limit_reset) begin
								good_run_count <= 6'h0;
								bad_run_count  <= 6'h0;
							end else if (id_ok) begin
								good_run_count <= good_run_count + 6'h1;
							end else if (bad_run_count + 6'h1 == bad_limit_to_lose) begin
								bad_run_count  <= 6'h0;
								state          <= ST_SEARCH;
								lock_lost_flag <= 1'b1;
							end else begin
								bad_run_count <= bad_run_count + 6'h1;
							end
						end
					end
					default: state <= ST_SEARCH;
				endcase
			end
		end
	end
	assign locked = state == ST_LOCK;
	// ==========================================================
	// host buffer: last, previous and one pending block
	reg [15:0] last_block_reg;
	reg [15:0] previous_block_reg;
	reg [15:0] pend_block;
	reg        pend_valid;
	reg        unread;
	reg        data_ready_flag;
	reg        overrun_flag;
	reg        hold;
	reg        dr_block;
	reg        pair_half;
	reg        new_blk_n;
	reg        irq_n;
	reg [31:0] nb_timer;
	wire       clr_byte = byte_rd && byte_no == ((mode == `RBS_MODE_PAIRED) ?
	                      `RBS_BYTE_PAIRCLR : `RBS_BYTE_PERCLR);
	wire       end_read = byte_rd && byte_no == `RBS_BYTE_LAST;
	wire [15:0] blk_data = window[25:10];
	// in fast mode during search only A or C' blocks deliver
	wire deliver = blk_done && blk_good &&
	               !(mode == `RBS_MODE_FAST && !locked &&
	                 blk_id != `RBS_ID_A && blk_id != `RBS_ID_CP);
	// paired mode flags only every second block
	wire flag_now = mode != `RBS_MODE_PAIRED || pair_half;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_block_reg     <= 16'h0;
			previous_block_reg <= 16'h0;
			pend_block         <= 16'h0;
			pend_valid         <= 1'b0;
			unread             <= 1'b0;
			data_ready_flag    <= 1'b0;
			overrun_flag       <= 1'b0;
			hold               <= 1'b0;
			dr_block           <= 1'b0;
			pair_half          <= 1'b0;
		end else begin
			// read sequence bookkeeping
			if (byte_rd && byte_no == `RBS_BYTE_FIRST) begin
				hold <= 1'b1;
			end
			if (clr_byte) begin
				dr_block        <= 1'b1;
				data_ready_flag <= 1'b0;
			end
			if (end_read) begin
				hold     <= 1'b0;
				dr_block <= 1'b0;
				unread   <= 1'b0;
				overrun_flag <= 1'b0;
				if (pend_valid && !deliver) begin
					last_block_reg     <= pend_block;
					previous_block_reg <= last_block_reg;
					pend_valid         <= 1'b0;
					unread             <= 1'b1;
				end
			end
			if (restart_search) begin
				overrun_flag <= 1'b0;
				pend_valid   <= 1'b0;
			end
			if (deliver) begin
				pair_half <= !pair_half;
				if (hold || (unread && overrun_flag)) begin
					pend_block <= blk_data; // kept until the host catches up
					pend_valid <= 1'b1;
				end else begin
					last_block_reg     <= blk_data;
					previous_block_reg <= last_block_reg;
					unread             <= 1'b1;
					if (unread) begin
						overrun_flag <= 1'b1; // set beats clear
					end
				end
				if (flag_now && !dr_block && !(clr_byte)) begin
					data_ready_flag <= 1'b1;
				end
			end
		end
	end
	// ==========================================================
	// new-block pulse and interrupt one-shot
	wire mask_read = rd_en && paddr == `RBS_REG_CTRL;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			new_blk_n <= 1'b1;
			irq_n     <= 1'b1;
			nb_timer  <= 32'h0;
		end else begin
			if (deliver) begin
				new_blk_n <= 1'b0;
				nb_timer  <= 32'h0;
			end else if (!new_blk_n) begin
				nb_timer <= nb_timer + 32'h1;
				if (end_read || nb_timer >= NBLK_CYC - 1) begin
					new_blk_n <= 1'b1;
				end
			end
			// lock, or block delivery with ready_irq_mask set, fires interrupt; a mask read only clears irq
			// lock_gain is registered with the state change; the state and id_ok have
			// already moved on by the time the delivered block is seen here
			if ((deliver && ready_irq_mask) || lock_gain) begin
				irq_n <= 1'b0;
			end else if (mask_read || end_read) begin
				irq_n <= 1'b1;
			end
		end
	end
	assign irq_out_n         = irq_n;
	assign new_block_pulse_n = new_blk_n;
	// ==========================================================
	// read mux, unmapped reads return zero
	always @* begin
		prdata = 32'h0;
		if (paddr == `RBS_REG_CTRL) begin
			prdata = {27'h0, 1'b0, ready_irq_mask, rbds, mode};
		end else if (paddr == `RBS_REG_LIMITS) begin
			prdata = {10'h0, bad_limit_to_acquire, 2'h0, good_limit_reset, 2'h0, bad_limit_to_lose};
		end else if (paddr == `RBS_REG_STATUS) begin
			prdata = {26'h0, locked, lock_lost_flag, overrun_flag, pend_valid, new_blk_n, data_ready_flag};
		end else if (paddr == `RBS_REG_COUNTS) begin
			prdata = {18'h0, bad_run_count, 2'h0, good_run_count};
		end else if (paddr == `RBS_REG_LAST) begin
			prdata = {16'h0, last_block_reg};
		end else if (paddr == `RBS_REG_PREV) begin
			prdata = {16'h0, previous_block_reg};
		end
	end
endmodule
`default_nettype wire

//--- hdl/rbs_syndrome.v
`timescale 1ns/10ps
`default_nettype none
module rbs_syndrome (
	// 26-bit window in
	input  wire [25:0] window,
	input  wire        rbds,
	// identity out
	output reg  [2:0]  ident
);
`include "rbs_defines.vh"
	reg [9:0] syn;
	integer   i;
	// ==========================================================
	// syndrome by long division with g(x)=x^10+x^8+x^7+x^5+x^4+x^3+1
	always @* begin
		syn = 10'h000;
		for (i = 25; i >= 0; i = i - 1) begin
			syn = {syn[8:0], window[i]} ^ (syn[9] ? 10'h1B9 : 10'h000);
		end
		// syndrome of the offset words decided as matched identity
		ident = `RBS_ID_NONE;
		if (syn == chk(`RBS_OFS_A)) begin
			ident = `RBS_ID_A;
		end else if (syn == chk(`RBS_OFS_B)) begin
			ident = `RBS_ID_B;
		end else if (syn == chk(`RBS_OFS_C)) begin
			ident = `RBS_ID_C;
		end else if (syn == chk(`RBS_OFS_CP)) begin
			ident = `RBS_ID_CP;
		end else if (syn == chk(`RBS_OFS_D)) begin
			ident = `RBS_ID_D;
		end else if (rbds && syn == chk(`RBS_OFS_E)) begin
			ident = `RBS_ID_E;
		end
	end
	// offset word reduced the same way, a zero data word being assumed
	function [9:0] chk;
		input [9:0] ofs;
		reg   [9:0] s;
		integer     k;
		begin
			s = 10'h000;
			for (k = 25; k >= 0; k = k - 1) begin
				s = {s[8:0], (k < 10) ? ofs[k] : 1'b0} ^ (s[9] ? 10'h1B9 : 10'h000);
			end
			chk = s;
		end
	endfunction
endmodule
`default_nettype wire

//--- pkg/rbs_defines.vh
// Contract
// - per-block mode copies each new block out, raises interrupt and data-ready (the code raises the interrupt only when ready_irq_mask is set)
// - host read of block registers clears data-ready; otherwise it stays set
// - new block pulses interrupt, sets data-ready, shifts last into previous (the code pulses the interrupt only when ready_irq_mask is set)
// - two new blocks without a host read set the overrun flag
// - timely read moves the pending block into last and clears overrun
// - fast mode sets no data-ready during search until an A or C' block
// - two good blocks in valid order give lock, locked bit and interrupt
// - fast mode without B still delivers the next A or C' block
// - locked fast mode flags every block if the flag was cleared first
// - paired mode flags data-ready only after every second new block
// - unlocked search slides a 26-bit syndrome window bit by bit
// - bad expected blocks count up; at acquire limit search restarts
// - RBDS with E first always expects A next
// - limits writable 0..63 and 0..32; run counts readable 0..63
// - bad run count reaching lose limit drops lock, sets lock-lost, restarts
// - good blocks count only while locked; reaching limit clears both counts
// - block read or restart-search write clears overrun; restart starts search
// - each decoded block pulses new-block low; with mask it fires interrupt
// - reading the mask register does not clear the new-block indicator
// - data-ready forced low from byte 15 or 17 until byte 19 read
// - new-block returns high at byte 19 read or after 10 ms at most
// - reading the flag and mask byte clears lock-lost
// - block data updates held off from byte 12 read until byte 19 read
`ifndef RBS_DEFINES_VH
`define RBS_DEFINES_VH
// ==========================================================
// register map (byte addresses)
`define RBS_REG_CTRL      12'h000
`define RBS_REG_LIMITS    12'h004
`define RBS_REG_STATUS    12'h008
`define RBS_REG_COUNTS    12'h00C
`define RBS_REG_LAST      12'h010
`define RBS_REG_PREV      12'h014
`define RBS_REG_RDBYTE    12'h018
`define RBS_REG_FLAGS     12'h01C
// ==========================================================
// control fields
`define RBS_CTRL_MODE_LO  0
`define RBS_CTRL_RBDS     2
`define RBS_CTRL_MASK     3
`define RBS_CTRL_RESTART  4
`define RBS_MODE_PER      2'h0
`define RBS_MODE_FAST     2'h1
`define RBS_MODE_PAIRED   2'h2
// ==========================================================
// reset values of the limits
`define RBS_BBL_RST       6'h0F
`define RBS_GBL_RST       6'h20
`define RBS_BBG_RST       5'h08
// ==========================================================
// offset words and identities
`define RBS_OFS_A         10'h0FC
`define RBS_OFS_B         10'h198
`define RBS_OFS_C         10'h168
`define RBS_OFS_CP        10'h350
`define RBS_OFS_D         10'h1B4
`define RBS_OFS_E         10'h000
`define RBS_ID_A          3'h0
`define RBS_ID_B          3'h1
`define RBS_ID_C          3'h2
`define RBS_ID_CP         3'h3
`define RBS_ID_D          3'h4
`define RBS_ID_E          3'h5
`define RBS_ID_NONE       3'h7
// ==========================================================
// read bytes of the host map
`define RBS_BYTE_FLAGS    5'h01
`define RBS_BYTE_FIRST    5'h0C
`define RBS_BYTE_PERCLR   5'h0F
`define RBS_BYTE_PAIRCLR  5'h11
`define RBS_BYTE_LAST     5'h13
// ==========================================================
// timing
`define RBS_CLK_NS        10
`define RBS_NBLK_MAX_MS   10
`define RBS_NBLK_CYC      ((`RBS_NBLK_MAX_MS * 1000000) / `RBS_CLK_NS)
`endif

//--- verification/rbs_bsb_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "rbs_defines.vh"
module rbs_bsb_checker #(
	parameter NBLK_CYC = 200
) (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb slave
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// bit stream and outputs
	input wire logic        rds_bit,
	input wire logic        rds_bit_clk,
	input wire logic        irq_out_n,
	input wire logic        new_block_pulse_n,
	input wire logic        locked
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================
	// bus steps
	sequence s_acc;
		psel && penable;
	endsequence
	sequence s_ctrl_rd;
		s_acc ##0 (!pwrite && paddr == `RBS_REG_CTRL);
	endsequence
	sequence s_byte19;
		s_acc ##0 (pwrite && paddr == `RBS_REG_RDBYTE && pwdata[4:0] == 5'h13);
	endsequence
	sequence s_restart;
		s_acc ##0 (pwrite && paddr == `RBS_REG_CTRL && pwdata[4]);
	endsequence
	// ==========================================
	// low time of the new-block indicator, too long for a repetition
	logic [31:0] low_cnt;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			low_cnt <= 32'h0;
		else if (new_block_pulse_n)
			low_cnt <= 32'h0;
		else
			low_cnt <= low_cnt + 32'h1;
	end
	// ==========================================
	// relations
	a_zero_wait: assert property (s_acc |-> pready) else $error("pready low in access");
	a_no_slverr: assert property (s_acc |-> !pslverr) else $error("pslverr raised");
	a_unmapped_zero: assert property (s_acc ##0 (!pwrite && paddr >= 12'h020) |-> prdata == 32'h0)
		else $error("unmapped read not zero");
	a_ctrl_read_irq: assert property (s_ctrl_rd |=> irq_out_n)
		else $error("irq kept after control read");
	a_byte19_release: assert property (s_byte19 |=> new_block_pulse_n)
		else $error("new block indicator kept after last byte");
	a_pulse_bounded: assert property (low_cnt <= NBLK_CYC)
		else $error("new block indicator low too long");
	a_restart_unlock: assert property (s_restart |=> !locked)
		else $error("lock kept after restart");
	a_lock_irq: assert property ($rose(locked) |-> ##[0:2] !irq_out_n)
		else $error("no interrupt on lock");
endmodule
bind rbs_block_sync_buffer rbs_bsb_checker #(.NBLK_CYC(NBLK_CYC)) u_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rds_bit(rds_bit),
	.rds_bit_clk(rds_bit_clk), .irq_out_n(irq_out_n), .new_block_pulse_n(new_block_pulse_n),
	.locked(locked));
`default_nettype wire

//--- verification/rbs_rds_src.sv
`timescale 1ns/10ps
`default_nettype none
module rbs_rds_src (
	// bench clock
	input wire logic pclk,
	// bit stream pins
	output logic     rds_bit,
	output logic     rds_bit_clk
);
	// ==========================================
	// checkword of 16 data bits, generator 0x5B9
	function automatic [9:0] chk(input [15:0] d);
		logic [25:0] r;
		r = {d, 10'h000};
		for (int i = 25; i >= 10; i--)
			if (r[i])
				r[i-:11] = r[i-:11] ^ 11'h5B9;
		chk = r[9:0];
	endfunction
	initial begin
		rds_bit = 1'b0;
		rds_bit_clk = 1'b0;
	end
	// one block msb first; bad spoils the checkword, clock stands low between blocks
	task automatic send(input [15:0] d, input [9:0] ofs, input bit bad);
		logic [25:0] w;
		w = {d, chk(d) ^ ofs ^ {9'h000, bad}};
		for (int i = 25; i >= 0; i--) begin
			rds_bit <= w[i];
			repeat (6) @(posedge pclk);
			rds_bit_clk <= 1'b1;
			repeat (6) @(posedge pclk);
			rds_bit_clk <= 1'b0;
		end
		// idle line must not repeat the last bit
		rds_bit <= ~w[0];
		@(posedge pclk);
	endtask
endmodule
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "rbs_defines.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
	$display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module tb;
	localparam NBLK = 300;
	logic        pclk, presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, rd;
	wire  [31:0] prdata;
	wire         pready, pslverr, rds_bit, rds_bit_clk, irq_out_n, new_block_pulse_n, locked;
	int          failures, samples_checked;
	always #5 pclk = ~pclk;
	rbs_block_sync_buffer #(.NBLK_CYC(NBLK)) u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .rds_bit(rds_bit),
		.rds_bit_clk(rds_bit_clk), .irq_out_n(irq_out_n),
		.new_block_pulse_n(new_block_pulse_n), .locked(locked));
	rbs_rds_src u_src (.pclk(pclk), .rds_bit(rds_bit), .rds_bit_clk(rds_bit_clk));
	// ==========================================
	// apb transfer, request held until pready is seen
	task automatic apb(input bit w, input [11:0] a, input [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic chk_reg(input [11:0] a, input [31:0] m, input [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd & m, e)
	endtask
	// host read of bytes 12..19 in one run
	task automatic host_read;
		for (int b = 12; b <= 19; b++) begin
			apb(1'b1, `RBS_REG_RDBYTE, b);
			if (b == 15)
				chk_reg(`RBS_REG_STATUS, 32'h1, 32'h0);
		end
	endtask
	task automatic final_report;
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset;
		`CHK({irq_out_n, new_block_pulse_n, locked}, 3'b110)
		chk_reg(`RBS_REG_LIMITS, 32'hFFFFFFFF, 32'h0008200F);
		chk_reg(12'h020, 32'hFFFFFFFF, 32'h0);
		apb(1'b1, `RBS_REG_LIMITS, 32'h003F2002);
		chk_reg(`RBS_REG_LIMITS, 32'hFFFFFFFF, 32'h00202002);
		apb(1'b1, `RBS_REG_CTRL, 32'h8);
	endtask
	task automatic t_sync;
		u_src.send(16'h1234, `RBS_OFS_A, 0);
		u_src.send(16'h5678, `RBS_OFS_B, 0);
		`CHK(locked, 1'b1)
		chk_reg(`RBS_REG_LAST, 32'hFFFF, 32'h5678);
		chk_reg(`RBS_REG_STATUS, 32'h3, 32'h1);
		repeat (NBLK + 20) @(posedge pclk);
		`CHK(new_block_pulse_n, 1'b1)
		host_read;
		chk_reg(`RBS_REG_STATUS, 32'h9, 32'h0);
	endtask
	task automatic t_buffer;
		u_src.send(16'h9ABC, `RBS_OFS_C, 0);
		`CHK(irq_out_n, 1'b0)
		apb(1'b0, `RBS_REG_CTRL, 32'h0);
		`CHK(irq_out_n, 1'b1)
		chk_reg(`RBS_REG_STATUS, 32'h3, 32'h1);
		u_src.send(16'hDEF0, `RBS_OFS_D, 0);
		chk_reg(`RBS_REG_PREV, 32'hFFFF, 32'h9ABC);
		chk_reg(`RBS_REG_LAST, 32'hFFFF, 32'hDEF0);
		chk_reg(`RBS_REG_STATUS, 32'h8, 32'h8);
		chk_reg(`RBS_REG_COUNTS, 32'h3F, 32'h02);
		apb(1'b1, `RBS_REG_CTRL, 32'h18);
		chk_reg(`RBS_REG_STATUS, 32'h28, 32'h0);
	endtask
	task automatic t_lose;
		u_src.send(16'h2345, `RBS_OFS_A, 0);
		u_src.send(16'h6789, `RBS_OFS_B, 0);
		`CHK(locked, 1'b1)
		// unread still stood, so the first block set overrun and the second block waits as pending until byte 19
		host_read;
		chk_reg(`RBS_REG_LAST, 32'hFFFF, 32'h6789);
		chk_reg(`RBS_REG_PREV, 32'hFFFF, 32'h2345);
		chk_reg(`RBS_REG_STATUS, 32'hC, 32'h0);
		u_src.send(16'h1111, `RBS_OFS_C, 1);
		chk_reg(`RBS_REG_COUNTS, 32'h3F00, 32'h0100);
		u_src.send(16'h2222, `RBS_OFS_D, 1);
		`CHK(locked, 1'b0)
		chk_reg(`RBS_REG_STATUS, 32'h10, 32'h10);
		apb(1'b1, `RBS_REG_RDBYTE, 32'h1);
		chk_reg(`RBS_REG_STATUS, 32'h10, 32'h0);
	endtask
	// ==========================================
	// main sequence and watchdog
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		failures = 0;
		samples_checked = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset;
		t_sync;
		t_buffer;
		t_lose;
		final_report;
	end
	initial begin
		#300000;
		failures++;
		final_report;
	end
endmodule
`default_nettype wire
